// ### logic/pmpdg_map.svh
`ifndef PMPDG_MAP_SVH
`define PMPDG_MAP_SVH

`define PMPDG_REG_CTRL 8'h00
`define PMPDG_REG_STATUS 8'h04
`define PMPDG_REG_REFUSED 8'h08

`define PMPDG_CTRL_LINK_EN 0
`define PMPDG_CTRL_CLR_CNT 1
`define PMPDG_CTRL_RESET 1'b1

`define PMPDG_ST_CODE_PROT 0
`define PMPDG_ST_WRITE_PROT 1
`define PMPDG_ST_DEBUG_EN 2
`define PMPDG_ST_CHAN_LO 3
`define PMPDG_ST_CHAN_HI 4
`define PMPDG_ST_CFG_LOADED 5
`define PMPDG_ST_LINK_BUSY 6

`define PMPDG_DBG_RAM_BYTES 80
`define PMPDG_CHANNELS 3
`define PMPDG_PROT_ACTIVE 1'b0
`define PMPDG_LINK_START 1'b1

`endif

// ### logic/pmpdg_pkg.sv
package pmpdg_pkg;

  typedef enum logic [1:0] {
    PMPDG_OP_READ,
    PMPDG_OP_WRITE,
    PMPDG_OP_ERASE
  } pmpdg_op_e;

  typedef enum logic [2:0] {
    PMPDG_L_IDLE,
    PMPDG_L_OP,
    PMPDG_L_ADDR,
    PMPDG_L_DATA,
    PMPDG_L_WAIT,
    PMPDG_L_SEND
  } pmpdg_link_e;

  typedef enum logic [1:0] {
    PMPDG_M_IDLE,
    PMPDG_M_INT,
    PMPDG_M_EXT
  } pmpdg_mem_e;

endpackage

// ### logic/pmpdg_tsync.sv
`timescale 1ns/10ps
`default_nettype none

// Toggle event crossing: three stages, an event counts once stages two and three agree
module pmpdg_tsync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tog_in,
  output logic pulse
);

  logic s1;
  logic s2;
  logic s3;
  logic seen;
  wire stable = (s2 == s3);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      seen <= 1'b0;
      pulse <= 1'b0;
    end else begin
      s1 <= tog_in;
      s2 <= s1;
      s3 <= s2;
      pulse <= stable && (s3 != seen);
      if (stable) begin
        seen <= s3;
      end
    end
  end

endmodule // pmpdg_tsync

`default_nettype wire

// ### logic/pmpdg_gate.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "pmpdg_map.svh"

module pmpdg_gate
  import pmpdg_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16,
  parameter int RAM_AW = 14,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  // Configuration storage, read once after reset
  input wire logic nv_general_code_protect_bit,
  input wire logic nv_general_write_protect_bit,
  input wire logic [1:0] nv_debug_channel_select_bits,
  input wire logic nv_debug_enable,
  // Programming / debug pin pairs
  input wire logic [2:0] prog_debug_clock_pin,
  input wire logic [2:0] prog_debug_data_pin_in,
  output logic [2:0] prog_debug_data_pin_out,
  output logic [2:0] prog_debug_data_pin_oe,
  // Internal program memory requests
  input wire logic int_req,
  input wire pmpdg_op_e int_op,
  input wire logic [ADDR_W-1:0] int_addr,
  input wire logic [DATA_W-1:0] int_wdata,
  output logic int_done,
  output logic int_refused,
  output logic [DATA_W-1:0] int_rdata,
  // Program memory port
  output logic mem_req,
  output pmpdg_op_e mem_op,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  // Data RAM user gate
  input wire logic ram_req,
  input wire logic [RAM_AW-1:0] ram_addr,
  output logic ram_grant,
  output logic ram_blocked,
  output logic [2:0] dbg_pin_reserved,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata
);

  function automatic logic [2:0] chan_mask(input logic [1:0] sel);
    unique case (sel)
      2'b11: chan_mask = 3'b001;
      2'b10: chan_mask = 3'b010;
      2'b01: chan_mask = 3'b100;
      default: chan_mask = 3'b000;
    endcase
  endfunction

  // ---------------- Configuration capture (system clock) ----------------
  // Safe values until the first edge after release: protected, no debug
  logic cfg_loaded;
  logic code_prot;
  logic write_prot;
  logic debug_en;
  logic [1:0] chan_sel;
  logic [2:0] sel_mask;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_loaded <= 1'b0;
      code_prot <= 1'b1;
      write_prot <= 1'b1;
      debug_en <= 1'b0;
      chan_sel <= 2'b00;
      sel_mask <= 3'b000;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      code_prot <= (nv_general_code_protect_bit == `PMPDG_PROT_ACTIVE);
      write_prot <= (nv_general_write_protect_bit == `PMPDG_PROT_ACTIVE);
      debug_en <= nv_debug_enable;
      chan_sel <= nv_debug_channel_select_bits;
      sel_mask <= chan_mask(nv_debug_channel_select_bits);
    end
  end

  // ---------------- Link side (programmer's clock) ----------------
  // Selection is static after reset, so the clock mux never switches mid-frame
  wire link_clk = |(prog_debug_clock_pin & sel_mask);
  wire link_din = |(prog_debug_data_pin_in & sel_mask);

  pmpdg_link_e lstate;
  logic [5:0] lcnt;
  logic l_is_read;
  logic [ADDR_W-1:0] l_addr;
  logic [DATA_W-1:0] l_wdata;
  logic [DATA_W:0] l_shout;
  logic l_req_tog;
  logic l_ack_pulse;
  logic l_busy;

  // Response words, held stable by the system side while its toggle is in flight
  logic resp_refused;
  logic [DATA_W-1:0] resp_rdata;
  logic resp_tog;

  pmpdg_tsync u_ack_sync (
    .clk(link_clk),
    .arst_n(arst_n),
    .tog_in(resp_tog),
    .pulse(l_ack_pulse)
  );

  wire l_cnt_zero = (lcnt == 6'h00);

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lstate <= PMPDG_L_IDLE;
      lcnt <= 6'h00;
      l_is_read <= 1'b0;
      l_addr <= '0;
      l_wdata <= '0;
      l_shout <= '0;
      l_req_tog <= 1'b0;
      l_busy <= 1'b0;
      prog_debug_data_pin_out <= 3'b000;
      prog_debug_data_pin_oe <= 3'b000;
    end else begin
      unique case (lstate)
        PMPDG_L_IDLE: begin
          if (link_din == `PMPDG_LINK_START) begin
            lstate <= PMPDG_L_OP;
            l_busy <= 1'b1;
          end
        end
        PMPDG_L_OP: begin
          l_is_read <= link_din;
          lcnt <= 6'(ADDR_W - 1);
          lstate <= PMPDG_L_ADDR;
        end
        PMPDG_L_ADDR: begin
          l_addr <= {l_addr[ADDR_W-2:0], link_din};
          lcnt <= lcnt - 6'h01;
          if (l_cnt_zero) begin
            if (l_is_read) begin
              l_req_tog <= ~l_req_tog;
              lstate <= PMPDG_L_WAIT;
            end else begin
              lcnt <= 6'(DATA_W - 1);
              lstate <= PMPDG_L_DATA;
            end
          end
        end
        PMPDG_L_DATA: begin
          l_wdata <= {l_wdata[DATA_W-2:0], link_din};
          lcnt <= lcnt - 6'h01;
          if (l_cnt_zero) begin
            l_req_tog <= ~l_req_tog;
            lstate <= PMPDG_L_WAIT;
          end
        end
        PMPDG_L_WAIT: begin
          if (l_ack_pulse) begin
            // Status bit first: one means the access was refused
            l_shout <= {resp_refused, resp_rdata};
            prog_debug_data_pin_out <= {3{resp_refused}} & sel_mask;
            prog_debug_data_pin_oe <= sel_mask;
            lcnt <= l_is_read ? 6'(DATA_W) : 6'h00;
            lstate <= PMPDG_L_SEND;
          end
        end
        PMPDG_L_SEND: begin
          if (l_cnt_zero) begin
            prog_debug_data_pin_oe <= 3'b000;
            prog_debug_data_pin_out <= 3'b000;
            l_busy <= 1'b0;
            lstate <= PMPDG_L_IDLE;
          end else begin
            l_shout <= {l_shout[DATA_W-1:0], 1'b0};
            prog_debug_data_pin_out <= {3{l_shout[DATA_W-1]}} & sel_mask;
            lcnt <= lcnt - 6'h01;
          end
        end
        default: lstate <= PMPDG_L_IDLE;
      endcase
    end
  end

  // ---------------- System side ----------------
  logic ext_pulse;
  logic ext_pend;
  logic int_pend;
  pmpdg_op_e ip_op;
  logic [ADDR_W-1:0] ip_addr;
  logic [DATA_W-1:0] ip_wdata;
  pmpdg_mem_e mstate;
  logic link_en;
  logic [CNT_W-1:0] refused_cnt;
  logic [1:0] busy_sync;
  logic link_busy;

  pmpdg_tsync u_req_sync (
    .clk(clk),
    .arst_n(arst_n),
    .tog_in(l_req_tog),
    .pulse(ext_pulse)
  );

  // Busy flag for status only; read by software, never steers logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_sync <= 2'b00;
      link_busy <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[0], l_busy};
      link_busy <= busy_sync[1];
    end
  end

  // Internal protection never looks at code_prot; only write/erase checks write_prot
  wire int_is_mod = (ip_op != PMPDG_OP_READ);
  wire int_block = int_is_mod && write_prot;
  // Whole address space is one segment: no address term in either decision
  wire ext_block = code_prot || !link_en || !cfg_loaded;
  wire serve_int = int_pend || int_req;
  wire int_take = int_pend && !int_req;
  wire refuse_evt = (mstate == PMPDG_M_IDLE) && ((int_take && int_block) || (!serve_int && ext_pend && ext_block));

  wire clr_cnt = reg_we && (reg_addr == `PMPDG_REG_CTRL) && reg_wdata[`PMPDG_CTRL_CLR_CNT];
  wire ext_op_is_read = l_is_read;

  // Internal request capture; one outstanding request at a time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_pend <= 1'b0;
      ip_op <= PMPDG_OP_READ;
      ip_addr <= '0;
      ip_wdata <= '0;
    end else begin
      if (int_req) begin
        int_pend <= 1'b1;
        ip_op <= int_op;
        ip_addr <= int_addr;
        ip_wdata <= int_wdata;
      end else if (mstate == PMPDG_M_IDLE) begin
        // Dropped as the arbiter takes it; waiting for done would issue it twice
        int_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_pend <= 1'b0;
    end else if (ext_pulse) begin
      ext_pend <= 1'b1;
    end else if (mstate == PMPDG_M_IDLE && !serve_int && ext_pend) begin
      ext_pend <= 1'b0;
    end
  end

  // Arbiter: internal accesses first when idle; a fetch still waits for an external access already in flight
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mstate <= PMPDG_M_IDLE;
      mem_req <= 1'b0;
      mem_op <= PMPDG_OP_READ;
      mem_addr <= '0;
      mem_wdata <= '0;
      int_done <= 1'b0;
      int_refused <= 1'b0;
      int_rdata <= '0;
      resp_refused <= 1'b0;
      resp_rdata <= '0;
      resp_tog <= 1'b0;
    end else begin
      mem_req <= 1'b0;
      int_done <= 1'b0;
      int_refused <= 1'b0;
      unique case (mstate)
        PMPDG_M_IDLE: begin
          if (int_pend && !int_req) begin
            if (int_block) begin
              int_refused <= 1'b1;
            end else begin
              mem_req <= 1'b1;
              mem_op <= ip_op;
              mem_addr <= ip_addr;
              mem_wdata <= ip_wdata;
              mstate <= PMPDG_M_INT;
            end
          end else if (!serve_int && ext_pend) begin
            if (ext_block) begin
              resp_refused <= 1'b1;
              resp_rdata <= '0;
              resp_tog <= ~resp_tog;
            end else begin
              mem_req <= 1'b1;
              mem_op <= ext_op_is_read ? PMPDG_OP_READ : PMPDG_OP_WRITE;
              mem_addr <= l_addr;
              mem_wdata <= l_wdata;
              mstate <= PMPDG_M_EXT;
            end
          end
        end
        PMPDG_M_INT: begin
          if (mem_ack) begin
            int_done <= 1'b1;
            int_rdata <= mem_rdata;
            mstate <= PMPDG_M_IDLE;
          end
        end
        PMPDG_M_EXT: begin
          if (mem_ack) begin
            resp_refused <= 1'b0;
            resp_rdata <= mem_rdata;
            resp_tog <= ~resp_tog;
            mstate <= PMPDG_M_IDLE;
          end
        end
        default: mstate <= PMPDG_M_IDLE;
      endcase
    end
  end

  // ---------------- Debug resource reservation ----------------
  wire ram_in_dbg = (ram_addr < RAM_AW'(`PMPDG_DBG_RAM_BYTES));
  wire ram_hit_dbg = debug_en && ram_in_dbg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_grant <= 1'b0;
      ram_blocked <= 1'b0;
      dbg_pin_reserved <= 3'b000;
    end else begin
      ram_grant <= ram_req && !ram_hit_dbg;
      ram_blocked <= ram_req && ram_hit_dbg;
      dbg_pin_reserved <= debug_en ? sel_mask : 3'b000;
    end
  end

  // ---------------- Register port ----------------
  wire [31:0] status_word = {25'h0000000, link_busy, cfg_loaded, chan_sel, debug_en, write_prot, code_prot};
  wire [31:0] ctrl_word = {31'h00000000, link_en};
  wire [31:0] cnt_word = 32'(refused_cnt);
  wire [31:0] rd_sel = (reg_addr == `PMPDG_REG_CTRL) ? ctrl_word :
                       (reg_addr == `PMPDG_REG_STATUS) ? status_word :
                       (reg_addr == `PMPDG_REG_REFUSED) ? cnt_word : 32'h00000000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_en <= `PMPDG_CTRL_RESET;
      refused_cnt <= '0;
      reg_rdata <= 32'h00000000;
    end else begin
      if (reg_we && reg_addr == `PMPDG_REG_CTRL) begin
        link_en <= reg_wdata[`PMPDG_CTRL_LINK_EN];
      end
      // A refusal in the clearing cycle still counts
      if (refuse_evt) begin
        refused_cnt <= clr_cnt ? CNT_W'(1) : refused_cnt + CNT_W'(1);
      end else if (clr_cnt) begin
        refused_cnt <= '0;
      end
      reg_rdata <= reg_re ? rd_sel : 32'h00000000;
    end
  end

endmodule // pmpdg_gate

`default_nettype wire

// ### tb/pmpdg_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pmpdg_checker
  import pmpdg_pkg::*;
#(parameter int RAM_AW = 14) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic nv_general_code_protect_bit,
  input wire logic nv_general_write_protect_bit,
  input wire logic [1:0] nv_debug_channel_select_bits,
  input wire logic nv_debug_enable,
  input wire logic [2:0] prog_debug_data_pin_out,
  input wire logic [2:0] prog_debug_data_pin_oe,
  input wire logic int_req,
  input wire pmpdg_op_e int_op,
  input wire logic int_refused,
  input wire logic mem_req,
  input wire logic ram_req,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic ram_grant,
  input wire logic ram_blocked,
  input wire logic [2:0] dbg_pin_reserved
);
  // Own copy of the config, so storage pins wiggled after reset are judged right
  logic up;
  logic cp, wp, dbg;
  logic [1:0] sel;
  wire logic [2:0] msk = {sel == 2'b01, sel == 2'b10, sel == 2'b11};
  wire logic blk = dbg && ram_addr < RAM_AW'(80);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up <= 1'b0;
    else up <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!up) {cp, wp, sel, dbg} <= {nv_general_code_protect_bit, nv_general_write_protect_bit,
      nv_debug_channel_select_bits, nv_debug_enable};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_WP_REFUSE: assert property (
    up && int_req && int_op != PMPDG_OP_READ && !wp |-> ##2 int_refused && !mem_req) else $error("no refusal");
  AST_INT_PASS: assert property (
    up && int_req && (int_op == PMPDG_OP_READ || wp) |-> ##2 mem_req && !int_refused) else $error("no access");
  AST_EXT_BLOCK: assert property (
    up && !cp && mem_req |-> $past(int_req, 2)) else $error("external access");
  AST_RAM_BLK: assert property (
    up && ram_req && blk |=> ram_blocked && !ram_grant) else $error("ram not blocked");
  AST_RAM_OK: assert property (
    up && ram_req && !blk |=> ram_grant && !ram_blocked) else $error("ram not granted");
  AST_OE_SEL: assert property (
    up |-> (prog_debug_data_pin_oe & ~msk) == 3'h0) else $error("oe on other pair");
  AST_OUT_SEL: assert property (
    up |-> (prog_debug_data_pin_out & ~msk) == 3'h0) else $error("data on other pair");
  AST_PIN_RES: assert property (
    up && $past(up) |-> dbg_pin_reserved == (dbg ? msk : 3'h0)) else $error("reserved pins");
endmodule // pmpdg_checker

bind pmpdg_gate pmpdg_checker #(.RAM_AW(RAM_AW)) u_chk (.clk, .arst_n, .nv_general_code_protect_bit,
  .nv_general_write_protect_bit, .nv_debug_channel_select_bits, .nv_debug_enable, .prog_debug_data_pin_out,
  .prog_debug_data_pin_oe, .int_req, .int_op, .int_refused, .mem_req, .ram_req, .ram_addr, .ram_grant,
  .ram_blocked, .dbg_pin_reserved);
`default_nettype wire

// ### tb/pmpdg_prog.sv
`timescale 1ns/10ps
`default_nettype none
module pmpdg_prog #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  output logic lclk,
  output logic pd,
  input wire logic dout,
  input wire logic doe
);
  initial begin
    lclk = 1'b0;
    pd = 1'b0;
  end
  // Clock only moves inside a frame
  task automatic tick;
    #80 lclk = 1'b1;
    #80 lclk = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    output logic st, output logic [DATA_W-1:0] q);
    logic [ADDR_W+DATA_W+1:0] sh;
    int n;
    sh = {1'b1, rd, a, d};
    n = rd ? ADDR_W + 2 : ADDR_W + DATA_W + 2;
    for (int i = 0; i < n; i++) begin
      pd = sh[ADDR_W+DATA_W+1-i];
      tick();
    end
    pd = 1'b0;
    for (int i = 0; i < 200 && !doe; i++) tick();
    st = doe ? dout : 1'bx;
    q = '0;
    if (rd) for (int i = 0; i < DATA_W; i++) begin
      tick();
      q = {q[DATA_W-2:0], dout};
    end
    tick();
  endtask
endmodule // pmpdg_prog
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pmpdg_pkg::*;
  logic clk, arst_n, int_req, mem_ack, ram_req, reg_we, reg_re, lclk, pd, st;
  logic int_done, int_refused, mem_req, ram_grant, ram_blocked;
  logic [4:0] nv, cf;
  logic [4:0] cfgs [3];
  pmpdg_op_e int_op, mem_op;
  logic [15:0] int_addr, int_wdata, int_rdata, mem_addr, mem_wdata, mem_rdata, q;
  logic [13:0] ram_addr;
  logic [2:0] dout, doe, dbg_pin_reserved, rnd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, nref;
  logic [33:0] last_mem;
  logic [1:0] wt;
  int seed = 46;
  int fail_count = 0;
  int cmp_count = 0;
  wire logic cp = cf[4];
  wire logic wp = cf[3];
  wire logic dbg = cf[0];
  wire logic [1:0] sel = cf[2:1];
  wire logic [2:0] msk = {sel == 2'b01, sel == 2'b10, sel == 2'b11};
  wire logic doe_s = |(doe & msk);
  // Programmer lets go of the line while the device drives it
  wire logic line = doe_s ? |(dout & msk) : pd;

  pmpdg_gate dut (.clk, .arst_n, .nv_general_code_protect_bit(nv[4]), .nv_general_write_protect_bit(nv[3]),
    .nv_debug_channel_select_bits(nv[2:1]), .nv_debug_enable(nv[0]),
    .prog_debug_clock_pin((msk & {3{lclk}}) | (~msk & rnd)),
    .prog_debug_data_pin_in((msk & {3{line}}) | (~msk & rnd)),
    .prog_debug_data_pin_out(dout), .prog_debug_data_pin_oe(doe),
    .int_req, .int_op, .int_addr, .int_wdata, .int_done, .int_refused, .int_rdata,
    .mem_req, .mem_op, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .ram_req, .ram_addr, .ram_grant, .ram_blocked, .dbg_pin_reserved,
    .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
  pmpdg_prog prog (.lclk, .pd, .dout(line), .doe(doe_s));

  always #2.5 clk = ~clk;
  // Program memory: answers after two or three cycles
  always @(posedge clk) begin
    rnd <= 3'($random(seed));
    mem_ack <= wt == 2'd1;
    if (mem_req) begin
      wt <= {1'b1, mem_addr[0]};
      last_mem <= {mem_op, mem_addr, mem_wdata};
      mem_rdata <= 16'($random(seed));
    end else if (wt != 2'd0) wt <= wt - 2'd1;
  end

  task automatic chk(input logic [33:0] e, input logic [33:0] g, input string n);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(e, reg_rdata, "reg_rdata");
  endtask
  task automatic intr(input pmpdg_op_e op);
    logic [15:0] a, d;
    logic rf;
    a = 16'($random(seed));
    d = 16'($random(seed));
    rf = op != PMPDG_OP_READ && !wp;
    @(posedge clk);
    int_req <= 1'b1;
    int_op <= op;
    int_addr <= a;
    int_wdata <= d;
    @(posedge clk);
    int_req <= 1'b0;
    repeat (20) begin
      #1;
      if (int_done === 1'b1 || int_refused === 1'b1) break;
      @(posedge clk);
    end
    chk(rf, int_refused, "int_refused");
    chk(!rf, int_done, "int_done");
    if (!rf) begin
      chk({op, a}, last_mem[33:16], "mem op addr");
      if (op != PMPDG_OP_READ) chk(d, last_mem[15:0], "mem wdata");
      else chk(mem_rdata, int_rdata, "int_rdata");
    end
    nref = nref + 32'(rf);
  endtask
  task automatic lnk(input logic r, input logic ok);
    logic [15:0] a, d;
    a = 16'($random(seed));
    d = 16'($random(seed));
    prog.frame(r, a, d, st, q);
    chk(!ok, st, "link status");
    if (r) chk(ok ? mem_rdata : 16'h0, q, "link data");
    else if (ok) chk({PMPDG_OP_WRITE, a, d}, last_mem, "link write");
    nref = nref + 32'(!ok);
  endtask
  task automatic results;
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    int_op = PMPDG_OP_READ;
    {int_req, int_addr, int_wdata, ram_req, ram_addr, reg_we, reg_re, reg_addr, reg_wdata} = '0;
    {wt, mem_ack, mem_rdata, rnd, nv} = '0;
    cfgs = '{5'b11111, 5'b00100, 5'b10011};
    for (int p = 0; p < 3; p++) begin
      @(posedge clk);
      nv <= cfgs[p];
      arst_n <= 1'b0;
      repeat (10) @(posedge clk);
      // Expected pair moves only while the gate is held in reset
      cf = cfgs[p];
      arst_n <= 1'b1;
      nref = 0;
      repeat (3) @(posedge clk);
      nv <= ~cfgs[p];
      rd(8'h04, {25'h0, 2'b01, sel, dbg, !wp, !cp});
      rd(8'h00, 32'h1);
      rd(8'h0c, 32'h0);
      intr(PMPDG_OP_WRITE);
      intr(PMPDG_OP_ERASE);
      repeat (5) intr(pmpdg_op_e'(2'($unsigned($random(seed)) % 3)));
      for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        ram_req <= 1'b1;
        ram_addr <= k < 2 ? 14'(79 + k) : 14'($unsigned($random(seed)) % 200);
        @(posedge clk);
        #1 chk(dbg && ram_addr < 14'd80, ram_blocked, "ram_blocked");
        chk(!(dbg && ram_addr < 14'd80), ram_grant, "ram_grant");
      end
      @(posedge clk);
      ram_req <= 1'b0;
      chk(dbg ? msk : 3'h0, dbg_pin_reserved, "reserved pins");
      lnk(1'b0, cp);
      lnk(1'b1, cp);
      wr(8'h00, 32'h0);
      lnk(1'b1, 1'b0);
      rd(8'h08, nref);
      wr(8'h00, 32'h3);
      rd(8'h08, 32'h0);
      rd(8'h00, 32'h1);
    end
    results();
  end
  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule // tb
`default_nettype wire
